// ### src/sdf_top.sv
`default_nettype none
module sdf_top
  import sdf_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_FRAME_SEL_N,
  input wire logic I_SER_CLK,
  input wire logic I_SER_DATA,
  input wire logic I_SUPPLY_LOW,
  input wire logic I_CORE_READY,
  output logic [15:0] O_CODE,
  output var sdf_pkg::sdf_mode_type O_MODE,
  output logic O_OUT_VALID,
  output logic O_WORD_VALID,
  output logic [17:0] O_WORD,
  output logic O_BUF_READY
);
  import sdf_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } sdf_state_type;

  function automatic sdf_mode_type mode_of(input logic [17:0] w);
    return sdf_mode_type'({w[MODE_HI_POS], w[MODE_LO_POS]});
  endfunction

  // Supply level picks the wake-up length when leaving power-down
  function automatic logic [10:0] wake_load(input logic low);
    return low ? 11'(WAKE_CYC_3V) : 11'(WAKE_CYC_5V);
  endfunction

  // Two-flop synchronisers; stage one is read only by stage two
  logic [2:0] s1_q, s2_q, s3_q;
  logic [2:0] s1_d, s2_d, s3_d;
  always_comb begin
    s1_d = {I_FRAME_SEL_N, I_SER_CLK, I_SER_DATA};
    s2_d = s1_q;
    s3_d = s2_q;
  end
  // Preset high so a select held low through reset is seen as a frame start
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end
  logic sel_n, sclk_fall, sel_fall, din;
  assign sel_n = s2_q[2];
  assign din = s2_q[0];
  assign sclk_fall = s3_q[1] && !s2_q[1];
  assign sel_fall = s3_q[2] && !s2_q[2];

  sdf_state_type st_q, st_d;
  logic [23:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic exec_q, exec_d;
  logic [17:0] word_q, word_d;
  logic buf_ready;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    exec_d = 1'b0;
    word_d = word_q;
    case (st_q)
      ST_IDLE: begin
        if (sel_fall) begin
          st_d = ST_SHIFT;
          cnt_d = CNT_RESET;
          sh_d = 24'h000000;
        end
      end
      ST_SHIFT: begin
        if (sel_n) begin
          st_d = ST_IDLE;
          sh_d = 24'h000000;
        end else if (sclk_fall) begin
          sh_d = {sh_q[22:0], din};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == CNT_LAST) begin
            st_d = ST_DONE;
            word_d = {sh_q[16:0], din};
            exec_d = 1'b1;
          end
        end
      end
      ST_DONE: begin
        // Extra clocks after the 24th edge are ignored until frame select rises
        if (sel_n) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      st_q <= ST_IDLE;
      sh_q <= 24'h000000;
      cnt_q <= CNT_RESET;
      exec_q <= 1'b0;
      word_q <= 18'h00000;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      exec_q <= exec_d;
      word_q <= word_d;
    end
  end

  // Buffer keeps words when the core stalls; a full buffer drops the newest
  logic bvalid;
  logic [17:0] bdata;
  logic take;
  sdf_buf2 u_buf (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_valid(exec_q),
    .o_ready(buf_ready),
    .i_data(word_q),
    .o_valid(bvalid),
    .i_ready(I_CORE_READY),
    .o_data(bdata)
  );
  assign take = bvalid && I_CORE_READY;
  assign O_WORD_VALID = bvalid;
  assign O_WORD = bdata;
  assign O_BUF_READY = buf_ready;

  logic [15:0] code_q, code_d;
  sdf_mode_type mode_q, mode_d;
  logic [10:0] wake_q, wake_d;
  logic valid_q, valid_d;

  always_comb begin
    code_d = code_q;
    mode_d = mode_q;
    wake_d = wake_q;
    valid_d = valid_q;
    if (wake_q != WAKE_RESET) begin
      wake_d = wake_q - 11'h001;
      if (wake_q == 11'h001) begin
        valid_d = 1'b1;
      end
    end
    if (take) begin
      mode_d = mode_of(bdata);
      code_d = bdata[CODE_BITS-1:0];
      if (mode_d != MODE_NORMAL) begin
        valid_d = 1'b0;
        wake_d = WAKE_RESET;
      end else if (mode_q != MODE_NORMAL) begin
        valid_d = 1'b0;
        wake_d = wake_load(I_SUPPLY_LOW);
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      code_q <= CODE_RESET;
      mode_q <= MODE_NORMAL;
      wake_q <= WAKE_RESET;
      valid_q <= 1'b1;
    end else begin
      code_q <= code_d;
      mode_q <= mode_d;
      wake_q <= wake_d;
      valid_q <= valid_d;
    end
  end

  assign O_CODE = code_q;
  assign O_MODE = mode_q;
  assign O_OUT_VALID = valid_q;

  a_abort_no_exec: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (st_q == ST_SHIFT && sel_n) |=> !exec_q)
    else $error("abort produced word");
  a_exec_count: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_d |-> cnt_q == CNT_LAST)
    else $error("word executed at wrong edge");
  a_shift_edge: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (st_q == ST_SHIFT && !sel_n && sclk_fall) |=> sh_q[0] == $past(din))
    else $error("bit not shifted");
  a_idle_ignore: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (st_q == ST_IDLE && !sel_fall) |=> st_q == ST_IDLE)
    else $error("frame began without select fall");
  a_code_update: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    take |=> O_CODE == $past(bdata[15:0]))
    else $error("code not loaded");
  a_code_hold: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    !take |=> $stable(O_CODE) && $stable(O_MODE))
    else $error("code changed without word");
  a_wake_delay: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (take && mode_q != MODE_NORMAL && bdata[17:16] == 2'h0 && !I_SUPPLY_LOW)
    |=> !O_OUT_VALID [*8])
    else $error("output valid too early");
  a_pd_invalid: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    O_MODE != MODE_NORMAL |-> !O_OUT_VALID)
    else $error("valid in power-down");

  // Independent count of taken falls, so the edge check does not lean on cnt_q
  logic [5:0] falls_q, falls_d;
  always_comb begin
    falls_d = falls_q;
    if (st_q == ST_IDLE) begin
      falls_d = 6'h00;
    end else if (st_q == ST_SHIFT && !sel_n && sclk_fall) begin
      falls_d = falls_q + 6'h01;
    end
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      falls_q <= 6'h00;
    end else begin
      falls_q <= falls_d;
    end
  end

  a_exec_frame: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    exec_q |-> falls_q == 6'(FRAME_BITS))
    else $error("word executed after wrong edge count");
  a_done_no_exec: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    st_q == ST_DONE |-> !exec_d)
    else $error("extra clocks executed a word");
  a_idle_no_exec: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    st_q == ST_IDLE |-> !exec_d)
    else $error("word executed outside a frame");
  a_frame_start: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (st_q == ST_IDLE && sel_fall) |=> (st_q == ST_SHIFT && cnt_q == CNT_RESET))
    else $error("frame did not start on select fall");
  a_abort_clear: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (st_q == ST_SHIFT && sel_n) |=> (st_q == ST_IDLE && sh_q == 24'h000000))
    else $error("partial frame kept");
  a_shift_count: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (st_q == ST_SHIFT && !sel_n && sclk_fall) |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("falling edge not counted");
  a_word_push: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (exec_q && buf_ready) |=> bvalid)
    else $error("word not buffered");
  a_mode_load: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    take |=> O_MODE == $past(mode_of(bdata)))
    else $error("mode not loaded");
  a_pd_entry: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (take && bdata[17:16] != 2'h0) |=> !O_OUT_VALID)
    else $error("output valid after power-down word");
  a_wake_load: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (take && mode_q != MODE_NORMAL && bdata[17:16] == 2'h0 && I_SUPPLY_LOW)
    |=> wake_q == 11'(WAKE_CYC_3V))
    else $error("low-supply wake length wrong");
  a_wake_count: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (wake_q != WAKE_RESET && !take) |=> wake_q == $past(wake_q) - 11'h001)
    else $error("wake counter skipped");
  a_wake_invalid: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    wake_q != WAKE_RESET |-> !O_OUT_VALID)
    else $error("valid during wake-up");
  a_valid_rise: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    $rose(O_OUT_VALID) |-> (O_MODE == MODE_NORMAL && wake_q == WAKE_RESET))
    else $error("valid rose early");
  a_valid_normal: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (take && mode_q == MODE_NORMAL && bdata[17:16] == 2'h0 && wake_q == WAKE_RESET)
    |=> O_OUT_VALID)
    else $error("normal word left output invalid");

  c_exec: cover property (@(posedge I_CLOCK) exec_q);
  c_abort: cover property (@(posedge I_CLOCK) st_q == ST_SHIFT && sel_n && cnt_q != CNT_RESET);
  c_wake: cover property (@(posedge I_CLOCK) wake_q == 11'h001);
  c_full: cover property (@(posedge I_CLOCK) !buf_ready);
  c_wake_low: cover property (@(posedge I_CLOCK) take && I_SUPPLY_LOW && mode_q != MODE_NORMAL);
endmodule
`default_nettype wire

// ### src/sdf_pkg.sv
`default_nettype none
package sdf_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 16;
  localparam int MODE_HI_POS = 17;
  localparam int MODE_LO_POS = 16;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [4:0] CNT_LAST = 5'h17;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam int CLK_MHZ = 200;
  localparam int WAKE_NS_5V = 2500;
  localparam int WAKE_NS_3V = 5000;
  localparam int WAKE_CYC_5V = (WAKE_NS_5V * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC_3V = (WAKE_NS_3V * CLK_MHZ + 999) / 1000;
  localparam logic [10:0] WAKE_RESET = 11'h000;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_GND_1K = 2'h1,
    MODE_GND_100K = 2'h2,
    MODE_HIGH_Z = 2'h3
  } sdf_mode_type;
endpackage
`default_nettype wire

// ### src/sdf_buf2.sv
`default_nettype none
module sdf_buf2 (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [17:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [17:0] o_data
);
  logic [17:0] mem_q [2];
  logic [17:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic rp_q, rp_d, wp_q, wp_d;
  logic push, pop;
  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rp_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wp_q] = i_data;
    end
    wp_d = push ? ~wp_q : wp_q;
    rp_d = pop ? ~rp_q : rp_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mem_q[0] <= 18'h00000;
      mem_q[1] <= 18'h00000;
      cnt_q <= 2'h0;
      rp_q <= 1'b0;
      wp_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rp_q <= rp_d;
      wp_q <= wp_d;
    end
  end
endmodule
`default_nettype wire

// ### tb/sdf_host.sv
`default_nettype none
module sdf_host (
  input wire logic i_clk,
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_sdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sel_n = 1'b1;
    o_sclk = 1'b1;
    o_sdata = 1'b0;
  end
  task automatic half();
    repeat (16) @(negedge i_clk);
  endtask
  // Fewer than 24 bits ends the frame early
  task automatic send(input logic [23:0] w, input int n);
    o_sel_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      o_sdata = w[i];
      half();
      o_sclk = 1'b0;
      half();
      o_sclk = 1'b1;
    end
    half();
    o_sel_n = 1'b1;
    o_sdata = ~o_sdata;
    half();
  endtask
  // Pulses with select high and a line that keeps changing
  task automatic stray();
    repeat (24) begin
      half();
      o_sclk = 1'b0;
      o_sdata = ~o_sdata;
      half();
      o_sclk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/sdf_top_test.sv
`default_nettype none
module sdf_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sdf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n, sclk, sdata, ov, wv, br;
  logic sup = 1'b0;
  logic rdy = 1'b0;
  logic [1:0] rmode = 2'h0;
  logic [7:0] lfsr = 8'h32;
  logic [15:0] code;
  logic [1:0] mode;
  logic [17:0] word, last;
  logic [17:0] notes[$];
  int miscompares = 0;
  int n_compared = 0;
  int n;
  initial forever #2.5 clk = ~clk;
  sdf_host host_u (.i_clk(clk), .o_sel_n(sel_n), .o_sclk(sclk), .o_sdata(sdata));
  sdf_top dut_u (.I_CLOCK(clk), .I_SYS_RST(rst), .I_FRAME_SEL_N(sel_n), .I_SER_CLK(sclk),
    .I_SER_DATA(sdata), .I_SUPPLY_LOW(sup), .I_CORE_READY(rdy), .O_CODE(code),
    .O_MODE(mode), .O_OUT_VALID(ov), .O_WORD_VALID(wv), .O_WORD(word), .O_BUF_READY(br));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    report_and_stop();
  endtask
  task automatic wr(input logic [1:0] m, input logic [15:0] c, input bit kept);
    if (kept)
      notes.push_back({m, c});
    host_u.send({6'h2A, m, c}, 24);
  endtask
  task automatic settle();
    n = 0;
    while (notes.size() != 0 || wv) begin
      @(negedge clk);
      if (++n > 3000)
        hang();
    end
    chk({mode, code}, last);
  endtask
  always @(negedge clk) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    rdy <= rmode[1] | (rmode[0] & lfsr[0]);
  end
  // The buffered word is checked as the consumer takes it
  always @(posedge clk) begin
    if (!rst && wv && rdy) begin
      last = (notes.size() != 0) ? notes.pop_front() : ~word;
      chk(word, last);
    end
  end
  initial begin
    last = 18'h0;
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk({mode, code}, 18'h0);
    chk({17'h0, ov}, 18'h1);
    rmode = 2'h1;
    for (int m = 0; m < 4; m++)
      wr(m[1:0], m == 0 ? 16'hFFFF : {lfsr, ~lfsr}, 1'b1);
    settle();
    $display("modes done");
    host_u.send(24'hFFFFFF, 1);
    host_u.send(24'hFFFFFF, 23);
    host_u.stray();
    settle();
    $display("abort done");
    rmode = 2'h0;
    wr(2'h0, 16'h1234, 1'b1);
    wr(2'h1, 16'h5678, 1'b1);
    wr(2'h2, 16'h9ABC, 1'b0);
    chk({17'h0, br}, 18'h0);
    rmode = 2'h1;
    settle();
    $display("buffer done");
    rmode = 2'h2;
    for (int s = 0; s < 2; s++) begin
      sup = s[0];
      wr(2'h3, 16'h0F0F, 1'b1);
      settle();
      chk({17'h0, ov}, 18'h0);
      fork
        wr(2'h0, 16'hA5A5, 1'b1);
        begin
          for (n = 0; mode !== 2'h0; n++) begin
            @(negedge clk);
            if (n > 1000)
              hang();
          end
          for (n = 0; !ov; n++) begin
            @(negedge clk);
            if (n > 1100)
              hang();
          end
          chk({17'h0, (n - (s ? WAKE_CYC_3V : WAKE_CYC_5V)) inside {[-2:2]}}, 18'h1);
        end
      join
      settle();
    end
    $display("wake done");
    report_and_stop();
  end
endmodule
`default_nettype wire
